// ### verilog/lock_loop_params.svh
// register indices, field positions and reset values of the lock loop control block
`ifndef LOCK_LOOP_PARAMS_SVH
`define LOCK_LOOP_PARAMS_SVH

`define IDX_L1_CONTROL 10'h171
`define IDX_L1_FORCED 10'h177
`define IDX_L1_STATUS 10'h178
`define IDX_L2_CONTROL 10'h191
`define IDX_L2_FORCED 10'h197
`define IDX_L2_STATUS 10'h198
`define IDX_L2_GAIN 10'h199
`define IDX_SYNC_ENABLE 10'h1a1
`define IDX_SYNC_INTEGER 10'h1a2
`define IDX_SYNC_NUMERATOR 10'h1a3
`define IDX_SYNC_DENOMINATOR 10'h1a4
`define IDX_SYNC_RATIO 10'h1a5
`define IDX_SYNC_REF_SELECT 10'h1a6
`define IDX_SYNC_GAIN_BW 10'h1a7
`define IDX_CLOCK_ROUTE 10'h1b0

`define ON_BIT 0
`define FREE_RUN_BIT 1
`define APPLY_BIT 15
`define VALID_BIT 15
`define GAIN_MSB 5
`define GAIN_LSB 2
`define OSC_DIV_MSB 10
`define OSC_DIV_LSB 8
`define REF_DIV_MSB 7
`define REF_DIV_LSB 6
`define REF_SRC_MSB 3
`define REF_SRC_LSB 0
`define BW_BIT 0

`define L1_FORCED_RST 12'h281
`define L2_FORCED_RST 12'h000
`define FREE_RUN_RST 1'b1
`define BW_RST 1'b1

`endif

// ### verilog/lock_loop_pkg.sv
// types of the lock loop control block
package lock_loop_pkg;

    typedef enum logic [1:0] {
        LOOP_OFF = 2'b00,
        LOOP_TRACK = 2'b01,
        LOOP_FREE = 2'b11
    } loop_state_t;

    typedef struct packed {
        loop_state_t st;
        logic on;
        logic free_run;
        logic [11:0] forced;
        logic [11:0] integ;
        logic ran;
        logic valid;
    } loop_t;

    typedef struct packed {
        logic loop2_sync_on;
        logic [9:0] loop2_sync_integer;
        logic [15:0] loop2_sync_numerator;
        logic [15:0] loop2_sync_denominator;
        logic [2:0] loop2_sync_osc_divider;
        logic [1:0] loop2_sync_ref_divider;
        logic [3:0] loop2_sync_ref_source;
        logic [3:0] loop2_sync_gain_code;
        logic loop2_sync_bandwidth_sel;
    } sync_cfg_t;

    typedef struct packed {
        loop_t [1:0] loop;
        logic [3:0] loop2_gain_code;
        sync_cfg_t sync;
        logic [1:0] sys_src;
        logic [1:0] async_src;
        logic [1:0] ref_m;
        logic [1:0] ref_s;
        logic ack;
        logic [31:0] dat;
        logic [8:0] gain2_val;
        logic [8:0] sync_gain_val;
        logic [4:0] osc_div_val;
        logic [3:0] ref_div_val;
        logic src_ok;
    } state_t;

endpackage : lock_loop_pkg

// ### verilog/lock_loop_sync_and_freerun_ctrl.sv
// lock loop synchroniser settings, free-running control and integrator model
//
// Design decision made here: the Wishbone slave port.
`include "lock_loop_params.svh"
`timescale 1ns/1ps

module lock_loop_sync_and_freerun_ctrl
    import lock_loop_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [11:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [1:0] ref_present_i,
    input wire logic [1:0][11:0] loop_error_i,
    output logic [1:0] loop_on_o,
    output logic [1:0] loop_free_running_o,
    output logic [1:0][11:0] loop_integrator_o,
    output logic [8:0] loop2_gain_o,
    output sync_cfg_t sync_cfg_o,
    output logic [8:0] sync_gain_o,
    output logic [4:0] sync_osc_div_o,
    output logic [3:0] sync_ref_div_o,
    output logic sync_ref_source_ok_o,
    output logic [1:0] main_system_clock_src_o,
    output logic [1:0] async_domain_clock_src_o
);

    state_t s_r;
    state_t s_nxt;
    logic [1:0] apply_hit;

    function automatic logic [8:0] gain_decode(input logic [3:0] code);
        gain_decode = code[3] ? 9'h100 : (9'h001 << code[2:0]);
    endfunction : gain_decode

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    function automatic logic [9:0] ctrl_idx(input int i);
        ctrl_idx = (i == 0) ? `IDX_L1_CONTROL : `IDX_L2_CONTROL;
    endfunction : ctrl_idx

    function automatic logic [9:0] forced_idx(input int i);
        forced_idx = (i == 0) ? `IDX_L1_FORCED : `IDX_L2_FORCED;
    endfunction : forced_idx

    function automatic logic [9:0] status_idx(input int i);
        status_idx = (i == 0) ? `IDX_L1_STATUS : `IDX_L2_STATUS;
    endfunction : status_idx

    always_comb begin
        logic hit;
        logic wr;
        logic [9:0] idx;
        logic [15:0] rd;
        logic [15:0] w;
        logic ref_ok;
        s_nxt = s_r;
        hit = cyc_i & stb_i & ~s_r.ack;
        wr = hit & we_i;
        idx = adr_i[11:2];
        rd = 16'h0000;
        w = 16'h0000;
        ref_ok = 1'b0;
        apply_hit = 2'b00;

        // reference presence comes from pins, so two flops first
        s_nxt.ref_m = ref_present_i;
        s_nxt.ref_s = s_r.ref_m;

        // one wait state answers every access, mapped or not
        s_nxt.ack = hit;

        // common synchroniser and gain registers
        if (idx == `IDX_L2_GAIN) begin
            rd[`GAIN_MSB:`GAIN_LSB] = s_r.loop2_gain_code;
            w = merge16(rd, dat_i, sel_i);
            if (wr) begin
                s_nxt.loop2_gain_code = w[`GAIN_MSB:`GAIN_LSB];
            end
        end else if (idx == `IDX_SYNC_ENABLE) begin
            rd[0] = s_r.sync.loop2_sync_on;
            w = merge16(rd, dat_i, sel_i);
            if (wr) begin
                s_nxt.sync.loop2_sync_on = w[0];
            end
        end else if (idx == `IDX_SYNC_INTEGER) begin
            rd[9:0] = s_r.sync.loop2_sync_integer;
            w = merge16(rd, dat_i, sel_i);
            if (wr) begin
                s_nxt.sync.loop2_sync_integer = w[9:0];
            end
        end else if (idx == `IDX_SYNC_NUMERATOR) begin
            rd = s_r.sync.loop2_sync_numerator;
            w = merge16(rd, dat_i, sel_i);
            if (wr) begin
                s_nxt.sync.loop2_sync_numerator = w;
            end
        end else if (idx == `IDX_SYNC_DENOMINATOR) begin
            rd = s_r.sync.loop2_sync_denominator;
            w = merge16(rd, dat_i, sel_i);
            if (wr) begin
                s_nxt.sync.loop2_sync_denominator = w;
            end
        end else if (idx == `IDX_SYNC_RATIO) begin
            rd[`OSC_DIV_MSB:`OSC_DIV_LSB] = s_r.sync.loop2_sync_osc_divider;
            w = merge16(rd, dat_i, sel_i);
            if (wr) begin
                s_nxt.sync.loop2_sync_osc_divider = w[`OSC_DIV_MSB:`OSC_DIV_LSB];
            end
        end else if (idx == `IDX_SYNC_REF_SELECT) begin
            rd[`REF_DIV_MSB:`REF_DIV_LSB] = s_r.sync.loop2_sync_ref_divider;
            rd[`REF_SRC_MSB:`REF_SRC_LSB] = s_r.sync.loop2_sync_ref_source;
            w = merge16(rd, dat_i, sel_i);
            if (wr) begin
                s_nxt.sync.loop2_sync_ref_divider = w[`REF_DIV_MSB:`REF_DIV_LSB];
                s_nxt.sync.loop2_sync_ref_source = w[`REF_SRC_MSB:`REF_SRC_LSB];
            end
        end else if (idx == `IDX_SYNC_GAIN_BW) begin
            rd[`GAIN_MSB:`GAIN_LSB] = s_r.sync.loop2_sync_gain_code;
            rd[`BW_BIT] = s_r.sync.loop2_sync_bandwidth_sel;
            w = merge16(rd, dat_i, sel_i);
            if (wr) begin
                s_nxt.sync.loop2_sync_gain_code = w[`GAIN_MSB:`GAIN_LSB];
                s_nxt.sync.loop2_sync_bandwidth_sel = w[`BW_BIT];
            end
        end else if (idx == `IDX_CLOCK_ROUTE) begin
            rd[3:0] = {s_r.async_src, s_r.sys_src};
            w = merge16(rd, dat_i, sel_i);
            if (wr) begin
                s_nxt.sys_src = w[1:0];
                s_nxt.async_src = w[3:2];
            end
        end

        for (int i = 0; i < 2; i++) begin
            // per-loop control, forced value and status registers
            if (idx == ctrl_idx(i)) begin
                rd[`ON_BIT] = s_r.loop[i].on;
                rd[`FREE_RUN_BIT] = s_r.loop[i].free_run;
                w = merge16(rd, dat_i, sel_i);
                if (wr) begin
                    s_nxt.loop[i].on = w[`ON_BIT];
                    s_nxt.loop[i].free_run = w[`FREE_RUN_BIT];
                end
            end else if (idx == forced_idx(i)) begin
                rd[11:0] = s_r.loop[i].forced;
                w = merge16(rd, dat_i, sel_i);
                if (wr) begin
                    s_nxt.loop[i].forced = w[11:0];
                    apply_hit[i] = sel_i[1] & dat_i[`APPLY_BIT];
                end
            end else if (idx == status_idx(i)) begin
                rd[`VALID_BIT] = s_r.loop[i].valid;
                rd[11:0] = s_r.loop[i].integ;
            end

            ref_ok = s_r.ref_s[i];
            // the integrator only accumulates while tracking; gain scaling is left to the error source
            case (s_r.loop[i].st)
                LOOP_OFF: begin
                    if (s_r.loop[i].on) begin
                        if (s_r.loop[i].free_run || !ref_ok) begin
                            s_nxt.loop[i].st = LOOP_FREE;
                            if (s_r.loop[i].free_run && !s_r.loop[i].ran) begin
                                s_nxt.loop[i].integ = s_r.loop[i].forced;
                            end
                        end else begin
                            s_nxt.loop[i].st = LOOP_TRACK;
                        end
                    end
                end
                LOOP_TRACK: begin
                    if (!s_r.loop[i].on) begin
                        s_nxt.loop[i].st = LOOP_OFF;
                    end else if (s_r.loop[i].free_run || !ref_ok) begin
                        s_nxt.loop[i].st = LOOP_FREE;
                    end else begin
                        s_nxt.loop[i].integ = s_r.loop[i].integ + loop_error_i[i];
                        s_nxt.loop[i].ran = 1'b1;
                    end
                end
                LOOP_FREE: begin
                    if (!s_r.loop[i].on) begin
                        s_nxt.loop[i].st = LOOP_OFF;
                    end else if (!s_r.loop[i].free_run && ref_ok) begin
                        s_nxt.loop[i].st = LOOP_TRACK;
                    end
                    // integrator held otherwise
                    if (s_r.loop[i].free_run && apply_hit[i]) begin
                        s_nxt.loop[i].integ = s_nxt.loop[i].forced;
                    end
                end
                default: begin
                    s_nxt.loop[i].st = LOOP_OFF;
                end
            endcase

            // valid only once a held value has settled in free-run
            s_nxt.loop[i].valid = (s_r.loop[i].st == LOOP_FREE) && (s_nxt.loop[i].st == LOOP_FREE)
                && s_nxt.loop[i].free_run;
        end

        s_nxt.dat = {16'h0000, rd};

        // decoded settings, registered so outputs come from flops
        s_nxt.gain2_val = gain_decode(s_nxt.loop2_gain_code);
        s_nxt.sync_gain_val = gain_decode(s_nxt.sync.loop2_sync_gain_code);
        s_nxt.osc_div_val = s_nxt.sync.loop2_sync_osc_divider[2] ? 5'h10
            : (5'h01 << s_nxt.sync.loop2_sync_osc_divider[1:0]);
        s_nxt.ref_div_val = 4'h1 << s_nxt.sync.loop2_sync_ref_divider;
        s_nxt.src_ok = s_nxt.sync.loop2_sync_ref_source[3]
            || (s_nxt.sync.loop2_sync_ref_source[3:1] == 3'h0)
            || (s_nxt.sync.loop2_sync_ref_source[3:1] == 3'h2);

        if (rst_i) begin
            s_nxt = '0;
            s_nxt.loop[0].free_run = `FREE_RUN_RST;
            s_nxt.loop[1].free_run = `FREE_RUN_RST;
            s_nxt.loop[0].forced = `L1_FORCED_RST;
            s_nxt.loop[1].forced = `L2_FORCED_RST;
            s_nxt.sync.loop2_sync_bandwidth_sel = `BW_RST;
            s_nxt.gain2_val = 9'h001;
            s_nxt.sync_gain_val = 9'h001;
            s_nxt.osc_div_val = 5'h01;
            s_nxt.ref_div_val = 4'h1;
            s_nxt.src_ok = 1'b1;
        end
    end

    // reset acts even while the clock enable is low
    always_ff @(posedge clk_i) begin
        if (ce_i || rst_i) begin
            s_r <= s_nxt;
        end
    end

    assign dat_o = s_r.dat;
    assign ack_o = s_r.ack;
    assign sync_cfg_o = s_r.sync;
    assign loop2_gain_o = s_r.gain2_val;
    assign sync_gain_o = s_r.sync_gain_val;
    assign sync_osc_div_o = s_r.osc_div_val;
    assign sync_ref_div_o = s_r.ref_div_val;
    assign sync_ref_source_ok_o = s_r.src_ok;
    assign main_system_clock_src_o = s_r.sys_src;
    assign async_domain_clock_src_o = s_r.async_src;

    for (genvar g = 0; g < 2; g++) begin : g_loop_out
        assign loop_on_o[g] = s_r.loop[g].on;
        // free is the only reachable state with the top bit set, so no gate after the flop
        assign loop_free_running_o[g] = s_r.loop[g].st[1];
        assign loop_integrator_o[g] = s_r.loop[g].integ;
    end

    property p_gain_decode;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !s_r.loop2_gain_code[3] |=> loop2_gain_o == (9'h001 << $past(s_r.loop2_gain_code[2:0]))
            || !ce_i || $past(cyc_i && stb_i && we_i);
    endproperty
    a_gain_decode: assert property (p_gain_decode) else $error("loop gain decode wrong");

    property p_osc_div;
        @(posedge clk_i) disable iff (rst_i)
        s_r.sync.loop2_sync_osc_divider[2] |-> sync_osc_div_o == 5'h10;
    endproperty
    a_osc_div: assert property (p_osc_div) else $error("oscillator divider decode wrong");

    property p_reset_values;
        @(posedge clk_i)
        $past(rst_i) && !rst_i |-> s_r.loop[0].free_run && s_r.loop[1].free_run
            && s_r.sync.loop2_sync_bandwidth_sel && !s_r.sync.loop2_sync_on && s_r.loop[0].forced == 12'h281;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

    property p_free_hold;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && s_r.loop[0].st == LOOP_FREE && !apply_hit[0] |=> $stable(s_r.loop[0].integ);
    endproperty
    a_free_hold: assert property (p_free_hold) else $error("integrator moved in free-run");

    property p_enter_keeps;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && s_r.loop[1].st == LOOP_TRACK && s_r.loop[1].on && s_r.loop[1].free_run
            |=> s_r.loop[1].st == LOOP_FREE && $stable(s_r.loop[1].integ);
    endproperty
    a_enter_keeps: assert property (p_enter_keeps) else $error("entering free-run changed integrator");

    property p_ref_loss;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && s_r.loop[0].st == LOOP_TRACK && s_r.loop[0].on && !s_r.ref_s[0] |=> s_r.loop[0].st == LOOP_FREE;
    endproperty
    a_ref_loss: assert property (p_ref_loss) else $error("lost reference did not free-run");

    property p_apply;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && apply_hit[0] && s_r.loop[0].free_run && s_r.loop[0].st == LOOP_FREE
            |=> s_r.loop[0].integ == s_r.loop[0].forced;
    endproperty
    a_apply: assert property (p_apply) else $error("forced integrator not applied");

    property p_cold_start;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && s_r.loop[1].st == LOOP_OFF && s_r.loop[1].on && s_r.loop[1].free_run && !s_r.loop[1].ran
            |=> s_r.loop[1].integ == s_r.loop[1].forced;
    endproperty
    a_cold_start: assert property (p_cold_start) else $error("cold start did not load forced value");

    property p_valid;
        @(posedge clk_i) disable iff (rst_i)
        s_r.loop[0].valid |-> s_r.loop[0].free_run && s_r.loop[0].st == LOOP_FREE;
    endproperty
    a_valid: assert property (p_valid) else $error("readback valid outside free-run");

    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus access not acknowledged");

endmodule : lock_loop_sync_and_freerun_ctrl

// ### verification/tb_lock_loop_sync_and_freerun_ctrl.sv
// testbench for the lock loop synchroniser and free-running control block
`timescale 1ns/1ps
`include "lock_loop_params.svh"

module tb_lock_loop_sync_and_freerun_ctrl
    import lock_loop_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [11:0] adr_i = 12'h000;
    logic [31:0] dat_i = 32'h0;
    logic [3:0] sel_i = 4'h0;
    logic we_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic [31:0] dat_o;
    logic ack_o;
    logic [1:0] ref_present_i = 2'b11;
    logic [1:0][11:0] loop_error_i = '0;
    logic [1:0] loop_on_o;
    logic [1:0] loop_free_running_o;
    logic [1:0][11:0] loop_integrator_o;
    logic [8:0] loop2_gain_o;
    sync_cfg_t sync_cfg_o;
    logic [8:0] sync_gain_o;
    logic [4:0] sync_osc_div_o;
    logic [3:0] sync_ref_div_o;
    logic sync_ref_source_ok_o;
    logic [1:0] main_system_clock_src_o;
    logic [1:0] async_domain_clock_src_o;
    int n_fail = 0;
    int num_checks = 0;
    logic [31:0] rd;
    logic [11:0] v1, v2;
    int i;

    lock_loop_sync_and_freerun_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .adr_i(adr_i),
        .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
        .ack_o(ack_o), .ref_present_i(ref_present_i), .loop_error_i(loop_error_i),
        .loop_on_o(loop_on_o), .loop_free_running_o(loop_free_running_o),
        .loop_integrator_o(loop_integrator_o), .loop2_gain_o(loop2_gain_o), .sync_cfg_o(sync_cfg_o),
        .sync_gain_o(sync_gain_o), .sync_osc_div_o(sync_osc_div_o), .sync_ref_div_o(sync_ref_div_o),
        .sync_ref_source_ok_o(sync_ref_source_ok_o), .main_system_clock_src_o(main_system_clock_src_o),
        .async_domain_clock_src_o(async_domain_clock_src_o));

    always #25 clk_i = ~clk_i;

    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle

    // classic cycle: request held until ack is sampled high at a rising edge
    task wb_xfer(input logic [9:0] idx, input logic w, input logic [15:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        adr_i <= {idx, 2'b00};
        we_i <= w;
        sel_i <= 4'hf;
        dat_i <= {16'h0, d};
        // no own limit here: a missing answer is left to the watchdog
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb_xfer

    task wr(input logic [9:0] idx, input logic [15:0] d);
        logic [31:0] q;
        wb_xfer(idx, 1'b1, d, q);
    endtask : wr

    task rd_chk(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        wb_xfer(idx, 1'b0, 16'h0, q);
        check(q, exp);
    endtask : rd_chk

    initial begin
        idle(20000);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        idle(2);
        rst_i <= 1'b0;
        // reset values
        rd_chk(`IDX_L1_CONTROL, 32'h0002);
        rd_chk(`IDX_L2_CONTROL, 32'h0002);
        rd_chk(`IDX_L1_FORCED, 32'h0281);
        rd_chk(`IDX_L2_FORCED, 32'h0000);
        rd_chk(`IDX_SYNC_ENABLE, 32'h0);
        rd_chk(`IDX_SYNC_INTEGER, 32'h0);
        rd_chk(`IDX_SYNC_NUMERATOR, 32'h0);
        rd_chk(`IDX_SYNC_DENOMINATOR, 32'h0);
        rd_chk(`IDX_SYNC_GAIN_BW, 32'h0001);
        rd_chk(`IDX_L1_STATUS, 32'h0);
        check(sync_gain_o, 32'd1);
        // every gain, divider and source code
        for (i = 0; i < 16; i++) begin
            wr(`IDX_L2_GAIN, 16'(i << 2));
            wr(`IDX_SYNC_GAIN_BW, 16'((i << 2) | (i & 1)));
            wr(`IDX_SYNC_RATIO, 16'((i & 7) << 8));
            wr(`IDX_SYNC_REF_SELECT, 16'(((i & 3) << 6) | i));
            idle(2);
            check(loop2_gain_o, (i < 8) ? 32'd1 << i : 32'd256);
            check(sync_gain_o, (i < 8) ? 32'd1 << i : 32'd256);
            check(sync_osc_div_o, (i & 4) ? 32'd16 : 32'd1 << (i & 3));
            check(sync_ref_div_o, 32'd1 << (i & 3));
            check(sync_ref_source_ok_o, 32'(i < 2 || i == 4 || i == 5 || i >= 8));
            check(sync_cfg_o.loop2_sync_bandwidth_sel, 32'(i & 1));
            rd_chk(`IDX_SYNC_REF_SELECT, 32'(((i & 3) << 6) | i));
        end
        wr(`IDX_SYNC_INTEGER, 16'hffff);
        wr(`IDX_SYNC_NUMERATOR, 16'hffff);
        wr(`IDX_SYNC_DENOMINATOR, 16'ha5a5);
        wr(`IDX_SYNC_ENABLE, 16'h0001);
        idle(2);
        rd_chk(`IDX_SYNC_INTEGER, 32'h03ff);
        rd_chk(`IDX_SYNC_NUMERATOR, 32'hffff);
        rd_chk(`IDX_SYNC_DENOMINATOR, 32'ha5a5);
        check(sync_cfg_o.loop2_sync_integer, 32'h3ff);
        check(sync_cfg_o.loop2_sync_on, 32'h1);
        // unmapped place reads zero and ignores writes
        wr(10'h100, 16'hffff);
        rd_chk(10'h100, 32'h0);
        // loop 1 cold start in free-running mode
        loop_error_i[0] <= 12'h005;
        wr(`IDX_L1_CONTROL, 16'h0003);
        idle(4);
        check(loop_free_running_o[0], 32'h1);
        check(loop_integrator_o[0], 32'h281);
        idle(10);
        check(loop_integrator_o[0], 32'h281);
        rd_chk(`IDX_L1_STATUS, 32'h8281);
        wr(`IDX_L1_FORCED, 16'h8123);
        idle(2);
        check(loop_integrator_o[0], 32'h123);
        rd_chk(`IDX_L1_FORCED, 32'h0123);
        wr(`IDX_L1_STATUS, 16'h0000);
        rd_chk(`IDX_L1_STATUS, 32'h8123);
        // loop 2 tracks; forced value not applied outside free-run
        wr(`IDX_L2_CONTROL, 16'h0001);
        idle(4);
        check(loop_free_running_o[1], 32'h0);
        wr(`IDX_L2_FORCED, 16'h8555);
        idle(2);
        check(loop_integrator_o[1], 32'h000);
        loop_error_i[1] <= 12'h001;
        idle(3);
        v1 = loop_integrator_o[1];
        idle(5);
        v2 = loop_integrator_o[1];
        check(v2, v1 + 12'h005);
        // clock enable low must freeze the tracking integrator
        ce_i <= 1'b0;
        idle(2);
        v1 = loop_integrator_o[1];
        idle(5);
        check(loop_integrator_o[1], v1);
        ce_i <= 1'b1;
        wr(`IDX_L2_CONTROL, 16'h0003);
        idle(4);
        v1 = loop_integrator_o[1];
        check(v1 == 12'h000, 32'h0);
        idle(10);
        check(loop_integrator_o[1], v1);
        rd_chk(`IDX_L2_STATUS, {20'h8, v1});
        // loss of reference forces free-run, then relock
        wr(`IDX_L1_CONTROL, 16'h0001);
        idle(4);
        check(loop_free_running_o[0], 32'h0);
        ref_present_i[0] <= 1'b0;
        idle(6);
        check(loop_free_running_o[0], 32'h1);
        ref_present_i[0] <= 1'b1;
        idle(6);
        check(loop_free_running_o[0], 32'h0);
        check(loop_on_o, 32'h3);
        wr(`IDX_L1_CONTROL, 16'h0000);
        idle(2);
        check(loop_on_o, 32'h2);
        // second reset, then loop 2 starts cold in free-running mode
        rst_i <= 1'b1;
        idle(2);
        rst_i <= 1'b0;
        rd_chk(`IDX_L2_CONTROL, 32'h0002);
        wr(`IDX_L2_CONTROL, 16'h0003);
        idle(4);
        check(loop_free_running_o[1], 32'h1);
        check(loop_integrator_o[1], 32'h000);
        rd_chk(`IDX_L2_STATUS, 32'h8000);
        // free-running loops as clock sources
        wr(`IDX_CLOCK_ROUTE, 16'h0009);
        idle(2);
        check(main_system_clock_src_o, 32'h1);
        check(async_domain_clock_src_o, 32'h2);
        stop_test();
    end
endmodule : tb_lock_loop_sync_and_freerun_ctrl
